// ### src/seia_params.svh
`ifndef SEIA_PARAMS_SVH
`define SEIA_PARAMS_SVH

// register indices; byte address is four times the index
`define SEIA_IDX_INSERT_COUNT 20'h3000C
`define SEIA_IDX_FRAMING_BYTE1 20'h3000D
`define SEIA_IDX_FRAMING_BYTE2 20'h3000E
`define SEIA_IDX_PARITY_MASK 20'h3000F
`define SEIA_IDX_GROUP_A_ALARM 20'h30010
`define SEIA_IDX_PAIR_ENABLE 20'h30011
`define SEIA_IDX_GROUP_B_ALARM 20'h30014
`define SEIA_IDX_INSERT_CMD 20'h30020
// matches no register; unaligned byte addresses decode to it
`define SEIA_IDX_NONE 20'hFFFFF

// field positions and widths
`define SEIA_COUNT_LSB 0
`define SEIA_COUNT_W 4
`define SEIA_ALARM_W 4

// reset values
`define SEIA_RST_BYTE 8'h00
`define SEIA_RST_COUNT 4'h0
`define SEIA_RST_ALARM 4'h0

// bus answer latency in clocks after the request is seen
`define SEIA_BUS_WAIT_CYCLES 1

`endif

// ### src/seia_pkg.sv
package seia_pkg;

  typedef struct packed {
    logic frame_start;
    logic is_framing1;
    logic is_framing2;
    logic is_parity;
    logic [7:0] data;
  } seia_lane_t;

  typedef enum logic [1:0] {
    SEIA_IDLE = 2'b00,
    SEIA_WAIT_FRAME = 2'b01,
    SEIA_INSERT = 2'b10
  } seia_state_t;

  typedef struct packed {
    logic [7:0] framing1;
    logic [7:0] framing2;
    logic [7:0] parity_mask;
    logic [3:0] count;
  } seia_insert_cfg_t;

endpackage

// ### src/seia_frame_insert.sv
`timescale 1ns/100ps
`include "seia_params.svh"

module seia_frame_insert (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic arm_i,
  input wire seia_pkg::seia_insert_cfg_t cfg_i,
  input wire seia_pkg::seia_lane_t lane_i,
  output logic [7:0] data_o,
  output logic done_o
);
  import seia_pkg::*;

  seia_state_t state_q, state_d;
  logic [`SEIA_COUNT_W-1:0] left_q, left_d;
  logic [7:0] data_q, data_d;
  logic done_q, done_d;

  ////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_d = state_q;
    left_d = left_q;
    done_d = 1'b0;
    case (state_q)
      SEIA_IDLE:
      begin
        if (arm_i)
        begin
          // a zero count corrupts nothing and finishes at once
          if (cfg_i.count == `SEIA_RST_COUNT)
            done_d = 1'b1;
          else
            state_d = SEIA_WAIT_FRAME;
        end
      end
      SEIA_WAIT_FRAME:
      begin
        if (lane_i.frame_start)
        begin
          left_d = cfg_i.count;
          state_d = SEIA_INSERT;
        end
      end
      SEIA_INSERT:
      begin
        if (lane_i.frame_start)
        begin
          if (left_q == `SEIA_COUNT_W'(1))
          begin
            state_d = SEIA_IDLE;
            done_d = 1'b1;
          end
          else
            left_d = left_q - `SEIA_COUNT_W'(1);
        end
      end
      default:
        state_d = SEIA_IDLE;
    endcase

    data_d = lane_i.data;
    // the frame-start byte already belongs to the frame being entered
    if (state_d == SEIA_INSERT && lane_i.is_framing1)
      data_d = cfg_i.framing1;
    else if (state_d == SEIA_INSERT && lane_i.is_framing2)
      data_d = cfg_i.framing2;
    else if (lane_i.is_parity)
      data_d = lane_i.data ^ cfg_i.parity_mask;
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      state_q <= SEIA_IDLE;
      left_q <= `SEIA_RST_COUNT;
      data_q <= `SEIA_RST_BYTE;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      left_q <= left_d;
      data_q <= data_d;
      done_q <= done_d;
    end
  end

  assign data_o = data_q;
  assign done_o = done_q;

endmodule

// ### src/seia_regs.sv
// Function
// - 8-bit RW framing byte 1 substitute, reset zero, replaces byte while inserting
// - 8-bit RW framing byte 2 substitute, reset zero, replaces byte while inserting
// - 8-bit RW mask; each one inverts matching transmitted parity bit
// - read-only group A consolidated alarms in bits 0 to 3, reset zero
// - RW pair enables bits 0 to 3 gate both group A and B alarms
// - insert command substitutes framing bytes for count consecutive frames
// - read-only group B consolidated alarms in bits 0 to 3, same enables
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "seia_params.svh"

module seia_regs #(
  parameter int PAIRS = 4
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic [21:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic [PAIRS-1:0] ALARM_SRC_A_I,
  input wire logic [PAIRS-1:0] ALARM_SRC_B_I,
  input wire seia_pkg::seia_lane_t TX_LANE_I [2*PAIRS],
  output logic [7:0] TX_DATA_O [2*PAIRS]
);
  import seia_pkg::*;

  localparam int CH = 2 * PAIRS;

  // alarm and enable registers hold at most four pairs
  generate
    if (PAIRS < 1 || PAIRS > `SEIA_ALARM_W)
    begin : gen_bad_pairs
      $error("PAIRS must lie between 1 and 4");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // register index from byte address; unaligned addresses match nothing
  function automatic logic [19:0] reg_index(input logic [21:0] addr);
    if (addr[1:0] != 2'b00)
      reg_index = `SEIA_IDX_NONE;
    else
      reg_index = addr[21:2];
  endfunction

  function automatic logic [7:0] widen_alarm(input logic [PAIRS-1:0] v);
    logic [7:0] r;
    r = 8'h00;
    r[PAIRS-1:0] = v;
    widen_alarm = r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, then the answer for exactly one cycle
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic take_req;
  logic do_write;
  logic [19:0] idx;
  logic [7:0] wbyte;

  assign idx = reg_index(AVS_ADDRESS_I);
  assign take_req = (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
  // writes land at the edge where the master sees waitrequest low
  assign do_write = AVS_WRITE_I & ack_q & AVS_BYTEENABLE_I[0];
  assign wbyte = AVS_WRITEDATA_I[7:0];
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
  assign AVS_READDATA_O = rdata_q;

  ////////////////////////////////////////////////////////////////////
  // software-written state
  logic [7:0] frm1_q, frm1_d;
  logic [7:0] frm2_q, frm2_d;
  logic [7:0] pmask_q, pmask_d;
  logic [`SEIA_COUNT_W-1:0] count_q, count_d;
  logic [PAIRS-1:0] enable_q, enable_d;
  logic [CH-1:0] cmd_q, cmd_d;
  logic [CH-1:0] arm_q, arm_d;
  logic [CH-1:0] done;

  // hardware-observed state
  logic [PAIRS-1:0] alarm_a_q, alarm_a_d;
  logic [PAIRS-1:0] alarm_b_q, alarm_b_d;

  always_comb
  begin
    frm1_d = frm1_q;
    frm2_d = frm2_q;
    pmask_d = pmask_q;
    count_d = count_q;
    enable_d = enable_q;
    arm_d = '0;
    // completion clears the command; a write in the same cycle wins
    cmd_d = cmd_q & ~done;
    if (do_write)
    begin
      if (idx == `SEIA_IDX_FRAMING_BYTE1)
        frm1_d = wbyte;
      else if (idx == `SEIA_IDX_FRAMING_BYTE2)
        frm2_d = wbyte;
      else if (idx == `SEIA_IDX_PARITY_MASK)
        pmask_d = wbyte;
      else if (idx == `SEIA_IDX_INSERT_COUNT)
        count_d = wbyte[`SEIA_COUNT_LSB +: `SEIA_COUNT_W];
      else if (idx == `SEIA_IDX_PAIR_ENABLE)
        enable_d = wbyte[PAIRS-1:0];
      else if (idx == `SEIA_IDX_INSERT_CMD)
      begin
        // idle or just-finishing channels start; a busy one keeps its run
        arm_d = wbyte[CH-1:0] & ~cmd_d;
        cmd_d = cmd_d | wbyte[CH-1:0];
      end
    end
    // status is the raw alarm gated by the shared pair enable
    alarm_a_d = ALARM_SRC_A_I & enable_q;
    alarm_b_d = ALARM_SRC_B_I & enable_q;
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      frm1_q <= `SEIA_RST_BYTE;
      frm2_q <= `SEIA_RST_BYTE;
      pmask_q <= `SEIA_RST_BYTE;
      count_q <= `SEIA_RST_COUNT;
      enable_q <= '0;
      cmd_q <= '0;
      arm_q <= '0;
      alarm_a_q <= '0;
      alarm_b_q <= '0;
    end
    else
    begin
      frm1_q <= frm1_d;
      frm2_q <= frm2_d;
      pmask_q <= pmask_d;
      count_q <= count_d;
      enable_q <= enable_d;
      cmd_q <= cmd_d;
      arm_q <= arm_d;
      alarm_a_q <= alarm_a_d;
      alarm_b_q <= alarm_b_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read mux; unmapped and unaligned words read zero
  always_comb
  begin
    ack_d = take_req;
    rdata_d = rdata_q;
    if (take_req && AVS_READ_I)
    begin
      rdata_d = 32'h0000_0000;
      if (idx == `SEIA_IDX_FRAMING_BYTE1)
        rdata_d[7:0] = frm1_q;
      else if (idx == `SEIA_IDX_FRAMING_BYTE2)
        rdata_d[7:0] = frm2_q;
      else if (idx == `SEIA_IDX_PARITY_MASK)
        rdata_d[7:0] = pmask_q;
      else if (idx == `SEIA_IDX_INSERT_COUNT)
        rdata_d[`SEIA_COUNT_LSB +: `SEIA_COUNT_W] = count_q;
      else if (idx == `SEIA_IDX_GROUP_A_ALARM)
        rdata_d[7:0] = widen_alarm(alarm_a_q);
      else if (idx == `SEIA_IDX_PAIR_ENABLE)
        rdata_d[7:0] = widen_alarm(enable_q);
      else if (idx == `SEIA_IDX_GROUP_B_ALARM)
        rdata_d[7:0] = widen_alarm(alarm_b_q);
      else if (idx == `SEIA_IDX_INSERT_CMD)
        rdata_d[CH-1:0] = cmd_q;
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // per-channel transmit insertion; channels 0..PAIRS-1 group A, rest B
  seia_insert_cfg_t cfg;

  // shared by all channels; count is read at the arm and again at the first frame start after it
  assign cfg = '{
    framing1: frm1_q,
    framing2: frm2_q,
    parity_mask: pmask_q,
    count: count_q
  };

  genvar g;
  generate
    for (g = 0; g < CH; g++)
    begin : gen_ch
      seia_frame_insert u_ins (
        .CORE_CLK_I(CORE_CLK_I),
        .RST_I(RST_I),
        .arm_i(arm_q[g]),
        .cfg_i(cfg),
        .lane_i(TX_LANE_I[g]),
        .data_o(TX_DATA_O[g]),
        .done_o(done[g])
      );
    end
  endgenerate

endmodule

// ### tb/seia_regs_props.sv
`timescale 1ns/100ps
module seia_regs_props
  import seia_pkg::*;
#(
  parameter int PAIRS = 4
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic [21:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic [PAIRS-1:0] ALARM_SRC_A_I,
  input wire logic [PAIRS-1:0] ALARM_SRC_B_I,
  input wire seia_pkg::seia_lane_t TX_LANE_I [2*PAIRS],
  input wire logic [7:0] TX_DATA_O [2*PAIRS]
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  logic req;
  assign req = AVS_READ_I | AVS_WRITE_I;
  sequence new_req;
    req && !$past(req);
  endsequence
  sequence rd_answer;
    AVS_READ_I && !AVS_WAITREQUEST_O;
  endsequence
  wait_first_a: assert property (new_req |-> AVS_WAITREQUEST_O)
    else $error("no wait in first request cycle");
  wait_one_a: assert property (req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("wait longer than one cycle");
  idle_free_a: assert property (!req |-> !AVS_WAITREQUEST_O)
    else $error("wait while idle");
  tx_plain0_a: assert property (TX_LANE_I[0][10:8] == 3'h0 |=>
    TX_DATA_O[0] == $past(TX_LANE_I[0].data)) else $error("plain byte altered");
  tx_plain7_a: assert property (TX_LANE_I[7][10:8] == 3'h0 |=>
    TX_DATA_O[7] == $past(TX_LANE_I[7].data)) else $error("plain byte altered");
  upper_zero_a: assert property (rd_answer ##0 (AVS_ADDRESS_I == 22'h0C0040 ||
    AVS_ADDRESS_I == 22'h0C0044 || AVS_ADDRESS_I == 22'h0C0050) |->
    AVS_READDATA_O[7:4] == 4'h0) else $error("upper bits not zero");
  quiet_a_a: assert property (rd_answer ##0 AVS_ADDRESS_I == 22'h0C0040 &&
    $past(ALARM_SRC_A_I, 3) == '0 && $past(ALARM_SRC_A_I, 2) == '0 && $past(ALARM_SRC_A_I) == '0
    |-> AVS_READDATA_O[3:0] == 4'h0) else $error("group a alarm without source");
  quiet_b_a: assert property (rd_answer ##0 AVS_ADDRESS_I == 22'h0C0050 &&
    $past(ALARM_SRC_B_I, 3) == '0 && $past(ALARM_SRC_B_I, 2) == '0 && $past(ALARM_SRC_B_I) == '0
    |-> AVS_READDATA_O[3:0] == 4'h0) else $error("group b alarm without source");
endmodule
////////////////////////////////////////
bind seia_regs seia_regs_props #(.PAIRS(PAIRS)) props_i (
  .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .ALARM_SRC_A_I(ALARM_SRC_A_I),
  .ALARM_SRC_B_I(ALARM_SRC_B_I), .TX_LANE_I(TX_LANE_I), .TX_DATA_O(TX_DATA_O)
);

// ### tb/seia_regs_test.sv
`timescale 1ns/100ps
`include "seia_params.svh"
module seia_regs_test;
  import seia_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [21:0] adr = 22'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] ben = 4'hF;
  logic [31:0] rdat;
  logic wq;
  logic [3:0] src_a = 4'h0;
  logic [3:0] src_b = 4'h0;
  seia_lane_t lane [8];
  logic [7:0] txd [8];
  logic [31:0] got;
  int err_count = 0;
  int compares = 0;

  seia_regs dut (
    .CORE_CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(ben),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wq), .ALARM_SRC_A_I(src_a),
    .ALARM_SRC_B_I(src_b), .TX_LANE_I(lane), .TX_DATA_O(txd)
  );
  ////////////////////////////////////////
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, seen);
      err_count++;
    end
  endtask

  // request held until waitrequest is seen low at a rising edge
  task bus(input logic w, input logic [19:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    wr <= w;
    rd <= ~w;
    @(posedge clk);
    while (wq !== 1'b0)
    begin
      n++;
      @(posedge clk);
    end
    chk("bus wait cycles", `SEIA_BUS_WAIT_CYCLES, n);
    got = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task rc(input logic [19:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    chk($sformatf("reg %h", idx), exp, got);
  endtask

  // one byte, then an idle byte; output looked at once settled
  task ln(input logic [11:0] v, input logic [7:0] exp);
    lane[0] <= v;
    @(posedge clk);
    lane[0] <= 12'h000;
    @(negedge clk);
    chk("tx byte", {24'h0, exp}, {24'h0, txd[0]});
    @(posedge clk);
  endtask

  task frame(input logic [7:0] e1, input logic [7:0] e2);
    ln(12'hCF6, e1);
    ln(12'h228, e2);
    ln(12'h011, 8'h11);
  endtask
  ////////////////////////////////////////
  task t_reset;
    rc(20'h3000D, 32'h0);
    rc(20'h3000E, 32'h0);
    rc(20'h3000F, 32'h0);
    rc(20'h30010, 32'h0);
    rc(20'h30011, 32'h0);
    rc(20'h30014, 32'h0);
  endtask

  task t_rw;
    bus(1'b1, 20'h3000D, 8'hA5);
    bus(1'b1, 20'h3000E, 8'h5A);
    bus(1'b1, 20'h3000F, 8'h81);
    ben <= 4'hE;
    bus(1'b1, 20'h3000D, 8'hFF);
    ben <= 4'hF;
    rc(20'h3000D, 32'hA5);
    rc(20'h3000E, 32'h5A);
    rc(20'h3000F, 32'h81);
    bus(1'b1, 20'h30011, 8'hFF);
    rc(20'h30011, 32'h0F);
    rc(20'h00100, 32'h0);
  endtask

  task t_alarm;
    src_a <= 4'hF;
    src_b <= 4'hB;
    bus(1'b1, 20'h30011, 8'hF5);
    rc(20'h30010, 32'h05);
    rc(20'h30014, 32'h01);
    bus(1'b1, 20'h30010, 8'hFF);
    rc(20'h30010, 32'h05);
    bus(1'b1, 20'h30011, 8'h00);
    rc(20'h30010, 32'h0);
    rc(20'h30014, 32'h0);
    src_a <= 4'h0;
    src_b <= 4'h0;
  endtask

  task t_parity;
    ln(12'h13C, 8'hBD);
    ln(12'h03C, 8'h3C);
    bus(1'b1, 20'h3000F, 8'h00);
    ln(12'h13C, 8'h3C);
  endtask

  // two frames substituted, the third start byte passes untouched
  task t_insert;
    bus(1'b1, 20'h3000C, 8'h02);
    bus(1'b1, 20'h30020, 8'h01);
    rc(20'h30020, 32'h01);
    frame(8'hA5, 8'h5A);
    frame(8'hA5, 8'h5A);
    frame(8'hF6, 8'h28);
    rc(20'h30020, 32'h0);
    bus(1'b1, 20'h3000C, 8'h00);
    bus(1'b1, 20'h30020, 8'h01);
    frame(8'hF6, 8'h28);
    rc(20'h30020, 32'h0);
  endtask
  ////////////////////////////////////////
  task stop_test;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    repeat (3000) @(posedge clk);
    err_count++;
    stop_test;
  end

  initial
  begin
    foreach (lane[i]) lane[i] = 12'h000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_rw;
    t_alarm;
    t_parity;
    t_insert;
    stop_test;
  end
endmodule
